/* src/ttr_defs.vh */
// Register map, field layout and timing constants of the timing register bank.
`ifndef TTR_DEFS_VH
`define TTR_DEFS_VH

`define TTR_IDX_W          8
`define TTR_IDX_CLOCK_GATING_CONTROL    8'h26
`define TTR_IDX_TURN       8'h27
`define TTR_IDX_HSYM_LO    8'h28
`define TTR_IDX_HSYM_HI    8'h29
`define TTR_IDX_SOFTWARE_RESET_STROBES    8'h2A

`define TTR_BIT_FIFO_CLK   3
`define TTR_TURN_MSB       7
`define TTR_TURN_LSB       4
`define TTR_TURN_RST       4'h4
`define TTR_TURN_MIN       4'h2
`define TTR_TURN_LOW       4'h8
`define TTR_BIT_RST_PWR    2
`define TTR_BIT_RST_BB     1
`define TTR_BIT_RST_MAC    0

`define TTR_SYMBOL_NS      16000
`define TTR_HSYM_UNIT_NS   8000
`define TTR_CLK_NS         10

`define TTR_BYTE_ZERO      8'h00
`define TTR_WORD_ZERO      32'h0000_0000
`define TTR_ADDR_LOW_ZERO  2'b00

`endif

/* src/ttr_regs.v */
// APB register bank for turnaround, half-symbol timer, clock gate and resets.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "ttr_defs.vh"

// This bank stores whatever software writes. The turnaround floor and the
// reserved-bit values are software duties, so a bad value reaches the
// timers unchanged. Clamping it here would hide a driver fault rather than
// expose it, so the bank passes it on as written.
// The reset strobes are pulses only and keep no state of their own.

module ttr_regs #(
	parameter SYMBOL_CYCLES = `TTR_SYMBOL_NS / `TTR_CLK_NS,
	parameter HSYM_CYCLES   = `TTR_HSYM_UNIT_NS / `TTR_CLK_NS
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	output wire        slotFifoClockEnable,
	output wire [3:0]  turnaroundInterval,
	output reg  [31:0] turnaroundCycles,
	output wire [15:0] halfSymbolTimerValue,
	output reg  [31:0] halfSymbolCycles,
	output reg         powerMgmtResetStrobe,
	output reg         basebandResetStrobe,
	output reg         linkLayerResetStrobe
);

	reg  [7:0] clockGatingControl;
	reg  [7:0] turnaroundTime;
	reg  [7:0] halfSymbolTimerLow;
	reg  [7:0] halfSymbolTimerHigh;
	wire       wrEn;
	wire       rdEn;
	wire [9:0] wordIdx;
	reg        hit;
	reg  [7:0] rdByte;
	wire       selGate;
	wire       selTurn;
	wire       selHsymLo;
	wire       selHsymHi;
	wire       selSoftRst;
	wire       wrGate;
	wire       wrTurn;
	wire       wrHsymLo;
	wire       wrHsymHi;
	wire       wrSoftRst;
	reg        next_powerMgmtResetStrobe;
	reg        next_basebandResetStrobe;
	reg        next_linkLayerResetStrobe;
	reg  [31:0] next_turnaroundCycles;
	reg  [31:0] next_halfSymbolCycles;
	reg  [31:0] next_prdata;

	// Registers take word slots; the printed offset 0x2A is not a
	// multiple of four, so each offset is an index times four.
	function [9:0] regAddr;
		input [7:0] idx;
		begin
			regAddr = {2'b00, idx};
		end
	endfunction

	// Every register select compares the bus word against one index, so the
	// comparison lives in one place.
	function isWord;
		input [9:0] word;
		input [7:0] idx;
		begin
			isWord = (word == regAddr(idx));
		end
	endfunction

	assign wordIdx = paddr[11:2];
	// Every access completes in its first access cycle; the bank never
	// needs to stall the bus.
	assign pready  = 1'b1;
	assign wrEn    = psel & penable & pwrite;
	// Reads are decoded in the setup cycle so the data is ready in time for
	// the completing edge of the access phase.
	assign rdEn    = psel & ~penable & ~pwrite;
	// Unmapped addresses read as zero and ignore writes; no error is raised.
	assign pslverr = 1'b0;

	assign selGate    = isWord(wordIdx, `TTR_IDX_CLOCK_GATING_CONTROL);
	assign selTurn    = isWord(wordIdx, `TTR_IDX_TURN);
	assign selHsymLo  = isWord(wordIdx, `TTR_IDX_HSYM_LO);
	assign selHsymHi  = isWord(wordIdx, `TTR_IDX_HSYM_HI);
	assign selSoftRst = isWord(wordIdx, `TTR_IDX_SOFTWARE_RESET_STROBES);

	// Writes land only at the access edge; a write's setup cycle never changes state.
	assign wrGate     = wrEn & selGate;
	assign wrTurn     = wrEn & selTurn;
	assign wrHsymLo   = wrEn & selHsymLo;
	assign wrHsymHi   = wrEn & selHsymHi;
	assign wrSoftRst  = wrEn & selSoftRst;

	assign slotFifoClockEnable  = clockGatingControl[`TTR_BIT_FIFO_CLK];
	assign turnaroundInterval   =
		turnaroundTime[`TTR_TURN_MSB:`TTR_TURN_LSB];
	assign halfSymbolTimerValue = {halfSymbolTimerHigh, halfSymbolTimerLow};

	// The read mux covers only mapped words; anything else clears hit so
	// that a stray address cannot put a stored byte on the bus.
	// The reset word reads as zero because its bits never hold a value.
	always @* begin
		hit    = 1'b1;
		rdByte = `TTR_BYTE_ZERO;
		case (wordIdx)
		regAddr(`TTR_IDX_CLOCK_GATING_CONTROL): rdByte = clockGatingControl;
		regAddr(`TTR_IDX_TURN):    rdByte = turnaroundTime;
		regAddr(`TTR_IDX_HSYM_LO): rdByte = halfSymbolTimerLow;
		regAddr(`TTR_IDX_HSYM_HI): rdByte = halfSymbolTimerHigh;
		// Strobe bits are write-only and always read back as zero.
		regAddr(`TTR_IDX_SOFTWARE_RESET_STROBES): rdByte = `TTR_BYTE_ZERO;
		default:                   hit = 1'b0;
		endcase
	end

	// Read data is captured in the setup cycle, so it already stands through
	// the access phase and the master can take it at the completing edge.
	// Unmapped words read as zero, which keeps stale bytes off the bus.
	always @* begin
		next_prdata = prdata;
		if (rdEn) begin
			if (hit)
				next_prdata = {24'h00_0000, rdByte};
			else
				next_prdata = `TTR_WORD_ZERO;
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			clockGatingControl  <= `TTR_BYTE_ZERO;
			// The low nibble resets to the value software must keep there,
			// so an untouched register is already in a legal state.
			turnaroundTime      <= {`TTR_TURN_RST, `TTR_TURN_LOW};
			halfSymbolTimerLow  <= `TTR_BYTE_ZERO;
			halfSymbolTimerHigh <= `TTR_BYTE_ZERO;
			prdata              <= `TTR_WORD_ZERO;
		end else begin
			if (wrGate)
				clockGatingControl <= pwdata[7:0];
			if (wrTurn)
				turnaroundTime <= pwdata[7:0];
			if (wrHsymLo)
				halfSymbolTimerLow <= pwdata[7:0];
			if (wrHsymHi)
				halfSymbolTimerHigh <= pwdata[7:0];
			prdata <= next_prdata;
		end
	end

	// Cycle counts follow the fields so downstream timers need no multiply.
	// They lag a field write by one clock; a timer that starts in the very
	// cycle of the write still sees the old length. The widest product,
	// the full timer times its unit, fits in the 32-bit result.
	always @* begin
		next_turnaroundCycles = turnaroundInterval * SYMBOL_CYCLES;
		next_halfSymbolCycles = halfSymbolTimerValue * HSYM_CYCLES;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			turnaroundCycles <= `TTR_WORD_ZERO;
			halfSymbolCycles <= `TTR_WORD_ZERO;
		end else begin
			turnaroundCycles <= next_turnaroundCycles;
			halfSymbolCycles <= next_halfSymbolCycles;
		end
	end

	// The strobes are decoded apart from the stored registers: nothing of a
	// strobe is kept, so a second write simply fires it again.
	always @* begin
		next_powerMgmtResetStrobe = 1'b0;
		next_basebandResetStrobe  = 1'b0;
		next_linkLayerResetStrobe = 1'b0;
		if (wrSoftRst) begin
			next_powerMgmtResetStrobe = pwdata[`TTR_BIT_RST_PWR];
			next_basebandResetStrobe  = pwdata[`TTR_BIT_RST_BB];
			next_linkLayerResetStrobe = pwdata[`TTR_BIT_RST_MAC];
		end
	end

	// Each strobe is high for exactly one clock after the write, then clears.
	always @(posedge clk) begin
		if (sys_rst) begin
			powerMgmtResetStrobe <= 1'b0;
			basebandResetStrobe  <= 1'b0;
			linkLayerResetStrobe <= 1'b0;
		end else begin
			powerMgmtResetStrobe <= next_powerMgmtResetStrobe;
			basebandResetStrobe  <= next_basebandResetStrobe;
			linkLayerResetStrobe <= next_linkLayerResetStrobe;
		end
	end

endmodule // ttr_regs

/* tb/ttr_regs_properties.sv */
// Port checks for the timing register bank.
`timescale 1ns/100ps
module ttr_regs_properties #(parameter SYMBOL_CYCLES = 1600,
	parameter HSYM_CYCLES = 800) (input wire clk, sys_rst, psel,
	penable, pwrite, pready, pslverr, slotFifoClockEnable,
	powerMgmtResetStrobe, basebandResetStrobe, linkLayerResetStrobe,
	input wire [11:0] paddr, input wire [3:0] turnaroundInterval,
	input wire [15:0] halfSymbolTimerValue, input wire [31:0] pwdata,
	prdata, turnaroundCycles, halfSymbolCycles);
	wire       wr = psel && penable && pwrite;
	wire [2:0] strb = {powerMgmtResetStrobe, basebandResetStrobe,
		linkLayerResetStrobe};
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence softWrite;
		wr && paddr == 12'h0A8;
	endsequence
	AST_NOERR: assert property (psel && penable
		|-> pready && !pslverr) else $error("bus error");
	AST_RDZERO: assert property (psel && !penable && !pwrite
		&& paddr == 12'h0A8 |=> prdata == 32'h0000_0000) else $error("rd");
	AST_GATE: assert property (wr && paddr == 12'h098
		|=> slotFifoClockEnable == $past(pwdata[3])) else $error("gate");
	AST_TURN: assert property (wr && paddr == 12'h09C
		|=> turnaroundInterval == $past(pwdata[7:4])) else $error("turn");
	AST_LO: assert property (wr && paddr == 12'h0A0
		|=> halfSymbolTimerValue[7:0] == $past(pwdata[7:0])) else $error("lo");
	AST_HI: assert property (wr && paddr == 12'h0A4
		|=> halfSymbolTimerValue[15:8] == $past(pwdata[7:0])) else $error("hi");
	AST_TCYC: assert property (1 |=> turnaroundCycles ==
		$past(turnaroundInterval) * SYMBOL_CYCLES) else $error("tcyc");
	AST_HCYC: assert property (1 |=> halfSymbolCycles ==
		$past(halfSymbolTimerValue) * HSYM_CYCLES) else $error("hcyc");
	AST_PWR: assert property (softWrite
		|=> strb == $past(pwdata[2:0])) else $error("strobe");
	AST_CLR: assert property (!(wr && paddr == 12'h0A8)
		|=> strb == 3'b000) else $error("strobe stuck");
endmodule // ttr_regs_properties
bind ttr_regs ttr_regs_properties #(.SYMBOL_CYCLES(SYMBOL_CYCLES),
	.HSYM_CYCLES(HSYM_CYCLES)) chk_u (.*);

/* tb/ttr_regs_tb.sv */
// Self-checking bench for the timing register bank.
`timescale 1ns/100ps
module ttr_regs_tb;
	reg        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd, v, s;
	reg        er;
	reg [7:0]  m [8'h26:8'h2A];
	wire       pready, pslverr, fifoClk, pwr, bb, mac;
	wire [31:0] prdata;
	wire [3:0] turn;
	wire [15:0] hsym;
	integer    failures = 0, num_checks = 0, i, t, n;
	always #5 clk = ~clk;
	ttr_regs dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.slotFifoClockEnable(fifoClk), .turnaroundInterval(turn),
		.turnaroundCycles(), .halfSymbolTimerValue(hsym),
		.halfSymbolCycles(), .powerMgmtResetStrobe(pwr),
		.basebandResetStrobe(bb), .linkLayerResetStrobe(mac));
	task chk(input [47:0] nm, input [31:0] e, g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("unexpected %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d failures %0d", num_checks, failures);
			if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	// Read data stands during the access phase and is taken at its edge.
	task apb(input w, input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			{psel, pwrite, paddr} <= {1'b1, w, 2'b00, a, 2'b00};
			pwdata <= {24'h00_0000, d};
			@(posedge clk);
			penable <= 1;
			n = 0;
			do begin
				@(posedge clk);
				n = n + 1;
			end while (pready !== 1'b1 && n < 16);
			rd = prdata;
			er = pslverr;
			{psel, penable} <= 2'b00;
			if (pready !== 1'b1) begin
				failures = failures + 1;
				$display("unexpected pready exp 1 got %b", pready);
				print_verdict;
			end
		end
	endtask
	initial begin
		v = $urandom(32'h2c6c_6f5a);
		for (i = 8'h26; i <= 8'h2A; i = i + 1) m[i] = 0;
		m[8'h27] = 8'h48;
		repeat (10) @(posedge clk);
		sys_rst <= 0;
		for (t = 0; t < 4; t = t + 1) begin
			for (i = 8'h26; i <= 8'h2B; i = i + 1) begin
				apb(0, i, 0);
				chk("rdata", (i == 8'h2B) ? 0 : m[i], rd);
				chk("slverr", 0, er);
			end
			chk("gate", m[8'h26][3], fifoClk);
			chk("turn", m[8'h27][7:4], turn);
			chk("hsym", {m[8'h29], m[8'h28]}, hsym);
			v = $urandom;
			m[8'h26] = v[7:0] & 8'h08;
			m[8'h27] = {v[11:8] | 4'h2, 4'h8};
			if (t == 3) m[8'h27] = 8'h38;
			{m[8'h29], m[8'h28]} = v[31:16];
			for (i = 8'h26; i <= 8'h29; i = i + 1) apb(1, i, m[i]);
			s = v[2:0] | (3'b001 << (t % 3));
			apb(1, 8'h2A, s);
			@(posedge clk);
			chk("strobe", s, {pwr, bb, mac});
			@(posedge clk);
			chk("strobe", 0, {pwr, bb, mac});
			$display("test %0d done", t);
		end
		print_verdict;
	end
endmodule // ttr_regs_tb
